// File: hdl/tfc_pkg.sv
// constants and carriers for the configuration and fan period count registers
// assumes a register port driven by a serial-bus protocol engine on the system clock
package tfc_pkg;
   localparam logic [7:0] CFG_ADDR      = 8'h03;
   localparam logic [7:0] CFG_ALT_ADDR  = 8'h09;
   localparam logic [7:0] ONE_SHOT_ADDR = 8'h0F;
   localparam logic [7:0] CNT_LOW_ADDR  = 8'h46;
   localparam logic [7:0] CNT_HIGH_ADDR = 8'h47;

   localparam int         ALERT_MASK_BIT  = 7;
   localparam int         LOW_POWER_BIT   = 6;
   localparam int         FAN_OFF_BIT     = 5;
   localparam int         TACH_EN_BIT     = 2;
   localparam int         CRIT_UNLOCK_BIT = 1;
   localparam int         FAULT_Q_BIT     = 0;
   localparam logic [7:0] CFG_WR_MASK     = 8'hE7;
   localparam logic [7:0] CFG_RESET       = 8'h00;

   localparam int         HIGH_BITS_LSB   = 6;
   localparam int         LOW_BITS_W      = 6;
   localparam logic [1:0] FAULT_Q_DEPTH   = 2'h3;
   localparam int         COUNT_WIDTH     = 16;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tfc_reg_req_t;

   typedef struct packed {
      logic out_en;
      logic out_val;
   } tfc_od_pin_t;
endpackage

// File: hdl/tfc_cfg_tach.sv
// configuration register, alert qualification, low-power control and fan period count
// assumes the protocol engine on clk issues one-cycle rd/wr strobes; the tach pin and the
// measuring clock tach_clk come from outside and are unrelated to clk
`timescale 1ns/100ps

module tfc_cfg_tach #(
   parameter int COUNT_W = tfc_pkg::COUNT_WIDTH
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  tach_clk,
   input  wire tfc_pkg::tfc_reg_req_t reg_req,
   output logic [7:0]                 rd_data,
   input  wire logic                  conv_done,
   input  wire logic                  remote_out_of_limit,
   output logic                       conv_continuous,
   output logic                       one_shot_start,
   output tfc_pkg::tfc_od_pin_t       alert_pin,
   input  wire logic                  fan_drive_in,
   input  wire logic                  fan_polarity,
   output logic                       fan_drive_out,
   output logic                       crit_limit_write_enable,
   input  wire logic                  tach_pin
);

   // the byte lanes of the count registers are laid out for a 16-bit count only
   if (COUNT_W != 16) begin : g_width_check
      $error("tfc_cfg_tach: COUNT_W must be 16");
   end

   function automatic logic is_cfg_write(input tfc_pkg::tfc_reg_req_t r);
      return r.wr && (r.addr == tfc_pkg::CFG_ADDR || r.addr == tfc_pkg::CFG_ALT_ADDR);
   endfunction

   // system clock domain state
   logic [7:0]         cfg_ff,       nxt_cfg;
   logic [1:0]         fault_cnt_ff, nxt_fault_cnt;
   logic               alert_ff,     nxt_alert;
   logic               one_shot_ff,  nxt_one_shot;
   logic               fan_ff,       nxt_fan;
   logic [7:0]         rd_data_ff,   nxt_rd_data;
   logic [7:0]         high_lock_ff, nxt_high_lock;
   logic [COUNT_W-1:0] count_ff,     nxt_count;
   logic               tgl_s1_ff, tgl_s2_ff, tgl_seen_ff;

   // measuring clock domain state
   logic               en_s1_ff, en_s2_ff;
   logic               pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic [COUNT_W-1:0] run_ff,  nxt_run;
   logic [COUNT_W-1:0] meas_ff, nxt_meas;
   logic               tgl_ff,  nxt_tgl;
   logic               tach_rise;

   logic hold;
   logic fan_off;
   logic new_meas;
   assign hold     = cfg_ff[tfc_pkg::LOW_POWER_BIT];
   assign fan_off  = cfg_ff[tfc_pkg::FAN_OFF_BIT];
   assign new_meas = tgl_s2_ff ^ tgl_seen_ff;

   always_comb begin
      nxt_cfg       = cfg_ff;
      nxt_fault_cnt = fault_cnt_ff;
      nxt_alert     = alert_ff;
      nxt_one_shot  = 1'b0;
      nxt_high_lock = high_lock_ff;
      nxt_rd_data   = rd_data_ff;
      nxt_count     = count_ff;
      if (is_cfg_write(reg_req)) begin
         nxt_cfg = reg_req.wdata & tfc_pkg::CFG_WR_MASK;
      end
      // the engine is told to convert once; repeated writes while busy are its concern
      if (reg_req.wr && reg_req.addr == tfc_pkg::ONE_SHOT_ADDR && hold) begin
         nxt_one_shot = 1'b1;
      end
      // comparator-style alert: a result back inside the limits releases it
      if (conv_done) begin
         if (remote_out_of_limit) begin
            if (!cfg_ff[tfc_pkg::FAULT_Q_BIT]) begin
               nxt_alert = 1'b1;
            end else if (fault_cnt_ff == tfc_pkg::FAULT_Q_DEPTH - 2'h1) begin
               nxt_alert = 1'b1;
            end
            if (fault_cnt_ff != tfc_pkg::FAULT_Q_DEPTH) begin
               nxt_fault_cnt = fault_cnt_ff + 2'h1;
            end
         end else begin
            nxt_fault_cnt = 2'h0;
            nxt_alert     = 1'b0;
         end
      end
      if (new_meas) begin
         nxt_count = meas_ff;
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            tfc_pkg::CFG_ADDR: begin
               nxt_rd_data = cfg_ff & tfc_pkg::CFG_WR_MASK;
            end
            tfc_pkg::CNT_LOW_ADDR: begin
               nxt_rd_data   = {count_ff[tfc_pkg::LOW_BITS_W-1:0], 2'h0};
               nxt_high_lock = count_ff[tfc_pkg::HIGH_BITS_LSB+7:tfc_pkg::HIGH_BITS_LSB];
            end
            tfc_pkg::CNT_HIGH_ADDR: begin
               nxt_rd_data = high_lock_ff;
            end
            default: begin
               nxt_rd_data = 8'h00;
            end
         endcase
      end
      if (hold && fan_off) begin
         nxt_fan = ~fan_polarity;
      end else begin
         nxt_fan = fan_drive_in;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_ff       <= tfc_pkg::CFG_RESET;
         fault_cnt_ff <= 2'h0;
         alert_ff     <= 1'b0;
         one_shot_ff  <= 1'b0;
         fan_ff       <= 1'b0;
         rd_data_ff   <= 8'h00;
         high_lock_ff <= 8'h00;
         count_ff     <= '0;
         tgl_s1_ff    <= 1'b0;
         tgl_s2_ff    <= 1'b0;
         tgl_seen_ff  <= 1'b0;
      end else begin
         cfg_ff       <= nxt_cfg;
         fault_cnt_ff <= nxt_fault_cnt;
         alert_ff     <= nxt_alert;
         one_shot_ff  <= nxt_one_shot;
         fan_ff       <= nxt_fan;
         rd_data_ff   <= nxt_rd_data;
         high_lock_ff <= nxt_high_lock;
         count_ff     <= nxt_count;
         tgl_s1_ff    <= tgl_ff;
         tgl_s2_ff    <= tgl_s1_ff;
         tgl_seen_ff  <= tgl_s2_ff;
      end
   end

   assign rd_data                 = rd_data_ff;
   assign conv_continuous         = ~hold;
   assign one_shot_start          = one_shot_ff;
   assign fan_drive_out           = fan_ff;
   assign crit_limit_write_enable = cfg_ff[tfc_pkg::CRIT_UNLOCK_BIT];
   // open drain: pulls low only while an alert stands and is not masked
   assign alert_pin               = '{out_en: alert_ff & ~cfg_ff[tfc_pkg::ALERT_MASK_BIT], out_val: 1'b0};

   // measuring domain: the period counter saturates rather than wrapping on a stalled fan
   assign tach_rise = pin_s2_ff & ~pin_s3_ff;

   always_comb begin
      nxt_run  = run_ff;
      nxt_meas = meas_ff;
      nxt_tgl  = tgl_ff;
      if (!en_s2_ff) begin
         nxt_run = '0;
      end else if (tach_rise) begin
         nxt_meas = run_ff;
         nxt_run  = {{(COUNT_W-1){1'b0}}, 1'b1};
         nxt_tgl  = ~tgl_ff;
      end else if (run_ff != {COUNT_W{1'b1}}) begin
         nxt_run = run_ff + {{(COUNT_W-1){1'b0}}, 1'b1};
      end
   end

   // meas_ff is held for a whole tach period, far longer than the toggle takes to cross
   always_ff @(posedge tach_clk or posedge reset) begin
      if (reset) begin
         en_s1_ff  <= 1'b0;
         en_s2_ff  <= 1'b0;
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
         run_ff    <= '0;
         meas_ff   <= '0;
         tgl_ff    <= 1'b0;
      end else begin
         en_s1_ff  <= cfg_ff[tfc_pkg::TACH_EN_BIT];
         en_s2_ff  <= en_s1_ff;
         pin_s1_ff <= tach_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         run_ff    <= nxt_run;
         meas_ff   <= nxt_meas;
         tgl_ff    <= nxt_tgl;
      end
   end

   sequence s_low_read;
      reg_req.rd && reg_req.addr == tfc_pkg::CNT_LOW_ADDR;
   endsequence
   sequence s_high_read;
      reg_req.rd && reg_req.addr == tfc_pkg::CNT_HIGH_ADDR;
   endsequence
   sequence s_bad_result;
      conv_done && remote_out_of_limit;
   endsequence

   property p_alert_mask;
      @(posedge clk) disable iff (reset) cfg_ff[tfc_pkg::ALERT_MASK_BIT] |-> !alert_pin.out_en;
   endproperty
   a_alert_mask: assert property (p_alert_mask) else $error("alert driven while masked");

   property p_run_mode;
      @(posedge clk) disable iff (reset)
         is_cfg_write(reg_req) && !reg_req.wdata[tfc_pkg::LOW_POWER_BIT] |=> conv_continuous;
   endproperty
   a_run_mode: assert property (p_run_mode) else $error("conversions not continuous");

   property p_hold_mode;
      @(posedge clk) disable iff (reset)
         is_cfg_write(reg_req) && reg_req.wdata[tfc_pkg::LOW_POWER_BIT] |=> !conv_continuous;
   endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("conversions run in hold");

   property p_one_shot;
      @(posedge clk) disable iff (reset)
         reg_req.wr && reg_req.addr == tfc_pkg::ONE_SHOT_ADDR && hold && !$past(one_shot_ff)
         |=> one_shot_start ##1 (!one_shot_start || $past(reg_req.wr));
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot not a single pulse");

   property p_fan_pass;
      @(posedge clk) disable iff (reset) !(hold && fan_off) |=> fan_drive_out == $past(fan_drive_in);
   endproperty
   a_fan_pass: assert property (p_fan_pass) else $error("fan drive not passed through");

   property p_fan_off;
      @(posedge clk) disable iff (reset) hold && fan_off |=> fan_drive_out == !$past(fan_polarity);
   endproperty
   a_fan_off: assert property (p_fan_off) else $error("fan drive not at off level");

   property p_reserved;
      @(posedge clk) disable iff (reset)
         reg_req.rd && reg_req.addr == tfc_pkg::CFG_ADDR |=> rd_data[4:3] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

   property p_tach_off;
      @(posedge tach_clk) disable iff (reset) !en_s2_ff |=> run_ff == '0;
   endproperty
   a_tach_off: assert property (p_tach_off) else $error("tach counting while disabled");

   property p_crit_lock;
      @(posedge clk) disable iff (reset)
         is_cfg_write(reg_req) |=> crit_limit_write_enable == $past(reg_req.wdata[tfc_pkg::CRIT_UNLOCK_BIT]);
   endproperty
   a_crit_lock: assert property (p_crit_lock) else $error("critical limit lock wrong");

   property p_single_fault;
      @(posedge clk) disable iff (reset) s_bad_result and !cfg_ff[tfc_pkg::FAULT_Q_BIT] |=> alert_ff;
   endproperty
   a_single_fault: assert property (p_single_fault) else $error("single fault missed");

   property p_queued_fault;
      @(posedge clk) disable iff (reset)
         s_bad_result and cfg_ff[tfc_pkg::FAULT_Q_BIT] && fault_cnt_ff < 2'h2 && !alert_ff |=> !alert_ff;
   endproperty
   a_queued_fault: assert property (p_queued_fault) else $error("alert before third fault");

   property p_measure;
      @(posedge tach_clk) disable iff (reset) en_s2_ff && tach_rise |=> meas_ff == $past(run_ff) && run_ff == 1;
   endproperty
   a_measure: assert property (p_measure) else $error("period not captured");

   property p_lock;
      @(posedge clk) disable iff (reset) s_low_read |=> high_lock_ff == $past(count_ff[13:6]);
   endproperty
   a_lock: assert property (p_lock) else $error("high byte not frozen");

   property p_high_byte;
      @(posedge clk) disable iff (reset) s_high_read |=> rd_data == $past(high_lock_ff);
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("high byte not from lock");

   property p_alias;
      @(posedge clk) disable iff (reset)
         reg_req.wr && reg_req.addr == tfc_pkg::CFG_ALT_ADDR ##1 reg_req.rd && reg_req.addr == tfc_pkg::CFG_ADDR
         && !reg_req.wr |=> rd_data == ($past(reg_req.wdata, 2) & tfc_pkg::CFG_WR_MASK);
   endproperty
   a_alias: assert property (p_alias) else $error("alias write not visible");

   property p_reset_cfg;
      @(posedge clk) $fell(reset) |-> cfg_ff == tfc_pkg::CFG_RESET;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config not cleared by reset");

endmodule // tfc_cfg_tach

// File: sim/tfc_fan_model.sv
// fan tachometer model: one rising tach edge every period measuring-clock cycles
// assumes period is at least 8 and changes only between measurements
`timescale 1ns/100ps
module tfc_fan_model (
   input  wire logic        tach_clk,
   input  wire logic        reset,
   input  wire logic [15:0] period,
   output logic             tach_pin
);
   logic [15:0] cnt_ff;

   always_ff @(posedge tach_clk or posedge reset) begin
      if (reset) begin
         cnt_ff   <= 16'h0000;
         tach_pin <= 1'h0;
      end else begin
         // wrap on >= so a shorter new period never overruns
         cnt_ff   <= (cnt_ff >= period - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
         tach_pin <= (cnt_ff < 16'h0004);
      end
   end
endmodule // tfc_fan_model

// File: sim/thermal_fan_config_tach_regs_test.sv
// self-checking bench for the configuration and fan period count registers
// assumes the register strobe port and the tach model in tfc_fan_model.sv
`timescale 1ns/100ps
module thermal_fan_config_tach_regs_test;
   localparam logic [15:0] P1 = 16'h0064;
   localparam logic [15:0] P2 = 16'h012C;
   logic                  clk;
   logic                  tach_clk;
   logic                  reset;
   logic                  conv_done;
   logic                  remote_out_of_limit;
   logic                  fan_drive_in;
   logic                  fan_polarity;
   logic                  conv_continuous;
   logic                  one_shot_start;
   logic                  fan_drive_out;
   logic                  crit_limit_write_enable;
   logic                  tach_pin;
   logic [7:0]            rd_data;
   logic [7:0]            d;
   logic [15:0]           fan_period;
   tfc_pkg::tfc_reg_req_t reg_req;
   tfc_pkg::tfc_od_pin_t  alert_pin;
   int                    n_errors;
   int                    checked;

   tfc_cfg_tach #(.COUNT_W(16)) tfc_cfg_tach_i (.clk(clk), .reset(reset), .tach_clk(tach_clk),
      .reg_req(reg_req), .rd_data(rd_data), .conv_done(conv_done), .remote_out_of_limit(remote_out_of_limit),
      .conv_continuous(conv_continuous), .one_shot_start(one_shot_start), .alert_pin(alert_pin),
      .fan_drive_in(fan_drive_in), .fan_polarity(fan_polarity), .fan_drive_out(fan_drive_out),
      .crit_limit_write_enable(crit_limit_write_enable), .tach_pin(tach_pin));
   tfc_fan_model tfc_fan_model_i (.tach_clk(tach_clk), .reset(reset), .period(fan_period), .tach_pin(tach_pin));

   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      tach_clk = 1'h0;
      #13.7;
      forever #40 tach_clk = ~tach_clk;
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
      @(posedge clk);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: wd};
      @(posedge clk);
      reg_req <= '0;
      #1 d = rd_data;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      acc(1'h0, a, 8'h00);
      chk(d, exp);
   endtask
   // write immediately followed by a read on the next edge, no idle cycle between
   task wr_rd(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra, input logic [7:0] exp);
      @(posedge clk);
      reg_req <= '{wr: 1'h1, rd: 1'h0, addr: wa, wdata: wd};
      @(posedge clk);
      reg_req <= '{wr: 1'h0, rd: 1'h1, addr: ra, wdata: 8'h00};
      @(posedge clk);
      reg_req <= '0;
      #1 d = rd_data;
      chk(d, exp);
   endtask
   task conv(input logic bad);
      @(posedge clk);
      conv_done           <= 1'h1;
      remote_out_of_limit <= bad;
      @(posedge clk);
      conv_done <= 1'h0;
      #1;
   endtask

   task t_reset;
      rd_chk(8'h03, 8'h00);
      chk(conv_continuous, 8'h01);
      chk(crit_limit_write_enable, 8'h00);
   endtask
   task t_cfg;
      // bit 2 stays clear so no measurement is taken before the disabled-tach check
      wr_rd(8'h09, 8'hFB, 8'h03, 8'hE3);
      rd_chk(8'h03, 8'hE3);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h20, 8'h00);
      chk(conv_continuous, 8'h00);
      chk(crit_limit_write_enable, 8'h01);
      acc(1'h1, 8'h47, 8'h55);
      rd_chk(8'h47, 8'h00);
   endtask
   task t_one_shot;
      acc(1'h1, 8'h0F, 8'h00);
      chk(one_shot_start, 8'h01);
      @(posedge clk);
      #1 chk(one_shot_start, 8'h00);
      acc(1'h1, 8'h03, 8'h00);
      acc(1'h1, 8'h0F, 8'h5A);
      chk(one_shot_start, 8'h00);
   endtask
   task t_fan;
      fan_drive_in <= 1'h1;
      fan_polarity <= 1'h1;
      acc(1'h1, 8'h03, 8'h60);
      repeat (3) @(posedge clk);
      #1 chk(fan_drive_out, 8'h00);
      fan_polarity <= 1'h0;
      repeat (3) @(posedge clk);
      #1 chk(fan_drive_out, 8'h01);
      acc(1'h1, 8'h03, 8'h40);
      fan_drive_in <= 1'h0;
      repeat (3) @(posedge clk);
      #1 chk(fan_drive_out, 8'h00);
      fan_drive_in <= 1'h1;
      repeat (3) @(posedge clk);
      #1 chk(fan_drive_out, 8'h01);
      acc(1'h1, 8'h03, 8'h00);
   endtask
   task t_alert;
      conv(1'h1);
      chk(alert_pin, 8'h02);
      conv(1'h0);
      chk(alert_pin, 8'h00);
      acc(1'h1, 8'h03, 8'h01);
      conv(1'h1);
      conv(1'h1);
      chk(alert_pin, 8'h00);
      conv(1'h0);
      conv(1'h1);
      conv(1'h1);
      chk(alert_pin, 8'h00);
      conv(1'h1);
      chk(alert_pin, 8'h02);
      conv(1'h0);
      acc(1'h1, 8'h03, 8'h80);
      conv(1'h1);
      chk(alert_pin, 8'h00);
      acc(1'h1, 8'h03, 8'h00);
      chk(alert_pin, 8'h02);
   endtask
   task t_tach;
      acc(1'h1, 8'h03, 8'h00);
      repeat (2000) @(posedge clk);
      rd_chk(8'h46, 8'h00);
      rd_chk(8'h47, 8'h00);
      acc(1'h1, 8'h03, 8'h04);
      rd_chk(8'h03, 8'h04);
      repeat (8000) @(posedge clk);
      rd_chk(8'h46, {P1[5:0], 2'h0});
      // the period grows before the high byte is fetched: it must stay frozen
      fan_period <= P2;
      repeat (8000) @(posedge clk);
      rd_chk(8'h47, P1[13:6]);
      rd_chk(8'h46, {P2[5:0], 2'h0});
      rd_chk(8'h47, P2[13:6]);
   endtask

   task conclude;
      if (n_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      n_errors            = 0;
      checked             = 0;
      reset               = 1'h1;
      reg_req             = '0;
      conv_done           = 1'h0;
      remote_out_of_limit = 1'h0;
      fan_drive_in        = 1'h0;
      fan_polarity        = 1'h0;
      fan_period          = P1;
      // reset acts asynchronously in both domains, so no measuring-clock edge is needed
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      t_reset;
      t_cfg;
      t_one_shot;
      t_fan;
      t_alert;
      t_tach;
      conclude;
   end
endmodule // thermal_fan_config_tach_regs_test
